// >>> verilog/pursq_sequencer.sv
// pursq_sequencer.sv: power-up and system reset sequencer with link clock bring-up
// assumes supervisor pins are asynchronous; firmware commands come from core_clk_i logic
`timescale 1ns/10ps
`include "pursq_defines.svh"

// Overview of operation
// - sense low: hold reset, tristate all pins
// - sense rising releases primary PLL reset
// - hold internal resets 60 ms after sense
// - supply warning: park mirrors, then reset
// - every system reset gives identical defaults
// - GPIO tristated during and after reset
// - primary PLL reset only on power-up
// - auto-release only processor and primary PLL resets
// - processor clocks at full rate after reset
// - link PLL down, clocks stopped, resets held
// - LVDS powered down, tristated, held in reset
// - external resets held until firmware release
// - processor boots from external flash
// - link clock bring-up in fixed order
module pursq_sequencer #(
    parameter int LOCK_DELAY_CYC = `PURSQ_LOCK_DELAY_CYC,
    parameter int PARK_TIMEOUT_CYC = `PURSQ_PARK_TIMEOUT_CYC
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic power_on_sense_i,
    input wire logic supply_good_warning_i,
    input wire logic watchdog_timeout_i,
    input wire logic park_done_i,
    input wire logic mirror_link_pll_locked_i,
    input wire pursq_pkg::pursq_fw_cmd_s fw_cmd_i,
    output pursq_pkg::pursq_ctrl_s ctrl_o,
    output logic [7:0] link_rate_o,
    output logic bringup_error_o
);
    import pursq_pkg::*;

    localparam int CNT_W = $clog2(LOCK_DELAY_CYC + 1);

    logic sense_s;
    logic good_s;
    logic lock_s;
    logic sense_prev;
    logic next_sense_prev;
    pursq_state_e state;
    pursq_state_e next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    pursq_bringup_e bu;
    pursq_bringup_e next_bu;
    pursq_ctrl_s ctrl;
    pursq_ctrl_s next_ctrl;
    logic [7:0] rate;
    logic [7:0] next_rate;
    logic rate_set;
    logic next_rate_set;
    logic error;
    logic next_error;
    logic [4:0] settle;
    logic [4:0] next_settle;
    logic sys_reset;

    // supervisor pins and the lock flag come from outside the clock domain
    pursq_sync #(.RESET_VALUE(1'b0)) u_sense_sync (
        .clk_i(core_clk_i),
        .reset_i(reset_i),
        .async_i(power_on_sense_i),
        .sync_o(sense_s)
    );
    // warning reads high while supplies are fine
    pursq_sync #(.RESET_VALUE(1'b0)) u_good_sync (
        .clk_i(core_clk_i),
        .reset_i(reset_i),
        .async_i(supply_good_warning_i),
        .sync_o(good_s)
    );
    pursq_sync #(.RESET_VALUE(1'b0)) u_lock_sync (
        .clk_i(core_clk_i),
        .reset_i(reset_i),
        .async_i(mirror_link_pll_locked_i),
        .sync_o(lock_s)
    );

    // watchdog comes from on-chip logic on this clock, no synchroniser
    // defaults land on the edge that enters reset, so no link clock or external
    // reset stays live for a cycle while the processor is already held
    assign sys_reset = (state == PURSQ_ST_OFF) || (state == PURSQ_ST_LOCK)
        || (state == PURSQ_ST_HOLD) || (next_state == PURSQ_ST_OFF)
        || (next_state == PURSQ_ST_HOLD);

    // main reset state machine
    always_comb begin
        next_state = state;
        next_count = count;
        next_sense_prev = sense_s;
        case (state)
            PURSQ_ST_OFF: begin
                next_count = '0;
                if (sense_s && !sense_prev) begin
                    next_state = PURSQ_ST_LOCK;
                end
            end
            PURSQ_ST_LOCK: begin
                if (!sense_s) begin
                    next_state = PURSQ_ST_OFF;
                end else if (count == CNT_W'(LOCK_DELAY_CYC - 1)) begin
                    next_count = '0;
                    next_state = PURSQ_ST_BOOT;
                end else begin
                    next_count = count + 1'b1;
                end
            end
            PURSQ_ST_BOOT, PURSQ_ST_RUN: begin
                next_count = '0;
                if (!sense_s) begin
                    next_state = PURSQ_ST_OFF;
                end else if (!good_s) begin
                    next_state = PURSQ_ST_PARK;
                end else if (watchdog_timeout_i) begin
                    next_state = PURSQ_ST_HOLD;
                end else if (state == PURSQ_ST_BOOT && bu == PURSQ_BU_DONE) begin
                    next_state = PURSQ_ST_RUN;
                end
            end
            PURSQ_ST_PARK: begin
                // a stuck park must not block the reset forever
                if (!sense_s) begin
                    next_state = PURSQ_ST_OFF;
                end else if (park_done_i || count == CNT_W'(PARK_TIMEOUT_CYC - 1)) begin
                    next_count = '0;
                    next_state = PURSQ_ST_HOLD;
                end else begin
                    next_count = count + 1'b1;
                end
            end
            PURSQ_ST_HOLD: begin
                // system reset held until the supply warning clears; primary PLL keeps running
                next_count = '0;
                if (!sense_s) begin
                    next_state = PURSQ_ST_OFF;
                end else if (good_s) begin
                    next_state = PURSQ_ST_BOOT;
                end
            end
            default: begin
                next_state = PURSQ_ST_OFF;
                next_count = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= PURSQ_ST_OFF;
            count <= '0;
            sense_prev <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            sense_prev <= next_sense_prev;
        end
    end

    // link clock bring-up, restarted by every system reset
    always_comb begin
        next_bu = bu;
        next_rate = rate;
        next_rate_set = rate_set;
        next_error = error;
        next_settle = settle;
        if (sys_reset) begin
            next_bu = PURSQ_BU_IDLE;
            next_rate = `PURSQ_RATE_RESET;
            next_rate_set = 1'b0;
            next_error = 1'b0;
            next_settle = '0;
        end else begin
            case (bu)
                PURSQ_BU_IDLE: begin
                    if (fw_cmd_i.program_rate) begin
                        next_rate = fw_cmd_i.rate;
                        next_rate_set = 1'b1;
                    end
                    if (fw_cmd_i.enable_pll) begin
                        if (rate_set || fw_cmd_i.program_rate) begin
                            next_bu = PURSQ_BU_PLL;
                        end else begin
                            next_error = 1'b1;
                        end
                    end
                end
                PURSQ_BU_PLL: begin
                    if (fw_cmd_i.set_clock_rate) begin
                        if (lock_s) begin
                            next_rate = fw_cmd_i.rate;
                            next_bu = PURSQ_BU_RATE;
                        end else begin
                            next_error = 1'b1;
                        end
                    end
                end
                PURSQ_BU_RATE: begin
                    if (fw_cmd_i.release_divider) begin
                        next_bu = PURSQ_BU_DIV;
                        next_settle = '0;
                    end
                end
                PURSQ_BU_DIV: begin
                    // derived clocks run a few cycles before external release
                    if (settle != 5'(`PURSQ_DIV_SETTLE_CYC)) begin
                        next_settle = settle + 5'h01;
                    end else if (fw_cmd_i.release_external) begin
                        next_bu = PURSQ_BU_DONE;
                    end
                end
                PURSQ_BU_DONE: begin
                    next_bu = PURSQ_BU_DONE;
                end
                default: begin
                    next_bu = PURSQ_BU_IDLE;
                end
            endcase
            // an external release request before the divider stage is flagged and otherwise ignored
            if (fw_cmd_i.release_external && bu != PURSQ_BU_DIV && bu != PURSQ_BU_DONE) begin
                next_error = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            bu <= PURSQ_BU_IDLE;
            rate <= `PURSQ_RATE_RESET;
            rate_set <= 1'b0;
            error <= 1'b0;
            settle <= '0;
        end else begin
            bu <= next_bu;
            rate <= next_rate;
            rate_set <= next_rate_set;
            error <= next_error;
            settle <= next_settle;
        end
    end

    // registered outputs, defaults re-applied on every system reset
    always_comb begin
        next_ctrl = ctrl;
        next_ctrl.primary_pll_reset = (next_state == PURSQ_ST_OFF);
        next_ctrl.cpu_reset = (next_state == PURSQ_ST_OFF) || (next_state == PURSQ_ST_LOCK)
            || (next_state == PURSQ_ST_HOLD);
        next_ctrl.io_tristate = (next_state == PURSQ_ST_OFF) || (next_state == PURSQ_ST_LOCK);
        next_ctrl.cpu_clock_full_rate = 1'b1;
        next_ctrl.boot_from_flash = (next_state == PURSQ_ST_BOOT);
        next_ctrl.park_request = (next_state == PURSQ_ST_PARK);
        next_ctrl.mirror_link_pll_powerdown = (next_bu == PURSQ_BU_IDLE);
        next_ctrl.link_divider_reset = (next_bu == PURSQ_BU_IDLE) || (next_bu == PURSQ_BU_PLL)
            || (next_bu == PURSQ_BU_RATE);
        next_ctrl.link_clock_enable = (next_bu == PURSQ_BU_DIV) || (next_bu == PURSQ_BU_DONE);
        next_ctrl.external_reset = (next_bu != PURSQ_BU_DONE);
        if (sys_reset || next_state == PURSQ_ST_OFF || next_state == PURSQ_ST_LOCK
            || next_state == PURSQ_ST_HOLD) begin
            next_ctrl.others_reset = 1'b1;
            next_ctrl.gpio_tristate = 1'b1;
            next_ctrl.lvds_powerdown = 1'b1;
            next_ctrl.lvds_reset = 1'b1;
        end else begin
            if (fw_cmd_i.release_others) begin
                next_ctrl.others_reset = 1'b0;
                next_ctrl.gpio_tristate = 1'b0;
            end
            if (fw_cmd_i.release_lvds) begin
                next_ctrl.lvds_powerdown = 1'b0;
                next_ctrl.lvds_reset = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl <= '{primary_pll_reset: 1'b1, cpu_reset: 1'b1, others_reset: 1'b1,
                gpio_tristate: 1'b1, io_tristate: 1'b1, mirror_link_pll_powerdown: 1'b1,
                link_divider_reset: 1'b1, link_clock_enable: 1'b0, lvds_powerdown: 1'b1,
                lvds_reset: 1'b1, external_reset: 1'b1, cpu_clock_full_rate: 1'b1,
                boot_from_flash: 1'b0, park_request: 1'b0};
        end else begin
            ctrl <= next_ctrl;
        end
    end

    assign ctrl_o = ctrl;
    assign link_rate_o = rate;
    assign bringup_error_o = error;
endmodule // pursq_sequencer

// >>> verilog/pursq_defines.svh
// pursq_defines.svh: timing counts and reset values for the power-up reset sequencer
// assumes the including file works on a 40 MHz core clock
`ifndef PURSQ_DEFINES_SVH
`define PURSQ_DEFINES_SVH

`define PURSQ_CLK_HZ 40000000
`define PURSQ_LOCK_DELAY_MS 60
`define PURSQ_LOCK_DELAY_CYC ((`PURSQ_CLK_HZ / 1000) * `PURSQ_LOCK_DELAY_MS)
`define PURSQ_PARK_TIMEOUT_CYC 1024
`define PURSQ_DIV_SETTLE_CYC 16
`define PURSQ_RATE_RESET 8'h00

`endif

// >>> verilog/pursq_pkg.sv
// pursq_pkg.sv: types shared by the power-up reset sequencer files
// assumes pursq_defines.svh holds the numeric constants
package pursq_pkg;

    typedef enum logic [5:0] {
        PURSQ_ST_OFF = 6'h01,
        PURSQ_ST_LOCK = 6'h02,
        PURSQ_ST_BOOT = 6'h04,
        PURSQ_ST_PARK = 6'h08,
        PURSQ_ST_HOLD = 6'h10,
        PURSQ_ST_RUN = 6'h20
    } pursq_state_e;

    typedef enum logic [4:0] {
        PURSQ_BU_IDLE = 5'h01,
        PURSQ_BU_PLL = 5'h02,
        PURSQ_BU_RATE = 5'h04,
        PURSQ_BU_DIV = 5'h08,
        PURSQ_BU_DONE = 5'h10
    } pursq_bringup_e;

    // firmware requests towards the sequencer, each a one-cycle pulse
    typedef struct packed {
        logic [7:0] rate;
        logic program_rate;
        logic enable_pll;
        logic set_clock_rate;
        logic release_divider;
        logic release_external;
        logic release_lvds;
        logic release_others;
    } pursq_fw_cmd_s;

    // reset and enable outputs of the sequencer
    typedef struct packed {
        logic primary_pll_reset;
        logic cpu_reset;
        logic others_reset;
        logic gpio_tristate;
        logic io_tristate;
        logic mirror_link_pll_powerdown;
        logic link_divider_reset;
        logic link_clock_enable;
        logic lvds_powerdown;
        logic lvds_reset;
        logic external_reset;
        logic cpu_clock_full_rate;
        logic boot_from_flash;
        logic park_request;
    } pursq_ctrl_s;

endpackage

// >>> verilog/pursq_sync.sv
// pursq_sync.sv: two-flop level synchroniser
// assumes the input is asynchronous to clk_i
`timescale 1ns/10ps
module pursq_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic async_i,
    output logic sync_o
);
    logic stage1;
    logic stage2;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            stage1 <= RESET_VALUE;
            stage2 <= RESET_VALUE;
        end else begin
            stage1 <= async_i;
            stage2 <= stage1;
        end
    end

    assign sync_o = stage2;
endmodule // pursq_sync

// >>> sim/pursq_sequencer_assertions.sv
// pursq_sequencer_assertions.sv: port-level checker for the power-up reset sequencer
// assumes it is bound to pursq_sequencer and sees only that module's ports
`timescale 1ns/10ps
module pursq_sequencer_checker #(
    parameter int LOCK_DELAY_CYC = 20,
    parameter int PARK_TIMEOUT_CYC = 8
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic power_on_sense_i,
    input wire logic supply_good_warning_i,
    input wire logic watchdog_timeout_i,
    input wire logic park_done_i,
    input wire logic mirror_link_pll_locked_i,
    input wire pursq_pkg::pursq_fw_cmd_s fw_cmd_i,
    input wire pursq_pkg::pursq_ctrl_s ctrl_o,
    input wire logic [7:0] link_rate_o,
    input wire logic bringup_error_o
);
    import pursq_pkg::*;
    localparam int LOCK_M1 = LOCK_DELAY_CYC - 1;
    // slack of four cycles above the timeout path, which reaches reset PARK_TIMEOUT_CYC cycles after the park request rises
    localparam int PARK_MAX = PARK_TIMEOUT_CYC + 4;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    property p_off_holds;
        !power_on_sense_i [*5] |-> ctrl_o.cpu_reset && ctrl_o.io_tristate
            && ctrl_o.gpio_tristate && ctrl_o.primary_pll_reset;
    endproperty
    a_off_holds: assert property (p_off_holds)
        else $error("outputs out of reset with sense low");
    property p_pll_release;
        $rose(power_on_sense_i) ##1 power_on_sense_i [*4] |-> !ctrl_o.primary_pll_reset;
    endproperty
    a_pll_release: assert property (p_pll_release)
        else $error("primary pll not released after sense rise");
    property p_lock_delay;
        $fell(ctrl_o.primary_pll_reset) |-> ##LOCK_M1 ctrl_o.cpu_reset ##1 !ctrl_o.cpu_reset;
    endproperty
    a_lock_delay: assert property (p_lock_delay)
        else $error("cpu reset release not at lock delay");
    property p_park_trigger;
        (!ctrl_o.cpu_reset && !supply_good_warning_i) [*5] |-> ctrl_o.park_request;
    endproperty
    a_park_trigger: assert property (p_park_trigger)
        else $error("no park request on supply warning");
    property p_park_then_reset;
        $rose(ctrl_o.park_request) |-> !ctrl_o.cpu_reset
            ##[1:PARK_MAX] (ctrl_o.cpu_reset && !ctrl_o.park_request);
    endproperty
    a_park_then_reset: assert property (p_park_then_reset)
        else $error("park not followed by system reset");
    property p_pll_kept;
        power_on_sense_i [*5] |-> !$rose(ctrl_o.primary_pll_reset);
    endproperty
    a_pll_kept: assert property (p_pll_kept)
        else $error("primary pll reset outside power-up");
    property p_boot_defaults;
        $fell(ctrl_o.cpu_reset) |-> ctrl_o.others_reset && ctrl_o.gpio_tristate
            && ctrl_o.mirror_link_pll_powerdown && ctrl_o.link_divider_reset
            && !ctrl_o.link_clock_enable && ctrl_o.lvds_powerdown && ctrl_o.lvds_reset
            && ctrl_o.external_reset && ctrl_o.cpu_clock_full_rate && ctrl_o.boot_from_flash;
    endproperty
    a_boot_defaults: assert property (p_boot_defaults)
        else $error("wrong defaults at processor release");
    property p_bringup_order;
        $fell(ctrl_o.external_reset) |-> !ctrl_o.link_divider_reset
            && ctrl_o.link_clock_enable && !ctrl_o.mirror_link_pll_powerdown;
    endproperty
    a_bringup_order: assert property (p_bringup_order)
        else $error("external reset released out of order");

    c_boot: cover property ($fell(ctrl_o.cpu_reset));
    c_park: cover property ($rose(ctrl_o.park_request));
    c_run: cover property ($fell(ctrl_o.external_reset));
endmodule // pursq_sequencer_checker

bind pursq_sequencer pursq_sequencer_checker #(
    .LOCK_DELAY_CYC(LOCK_DELAY_CYC),
    .PARK_TIMEOUT_CYC(PARK_TIMEOUT_CYC)
) u_checker (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .power_on_sense_i(power_on_sense_i),
    .supply_good_warning_i(supply_good_warning_i),
    .watchdog_timeout_i(watchdog_timeout_i),
    .park_done_i(park_done_i),
    .mirror_link_pll_locked_i(mirror_link_pll_locked_i),
    .fw_cmd_i(fw_cmd_i),
    .ctrl_o(ctrl_o),
    .link_rate_o(link_rate_o),
    .bringup_error_o(bringup_error_o)
);

// >>> sim/pursq_supervisor.sv
// pursq_supervisor.sv: behavioural supply supervisor, mirror array and link pll
// assumes the bench steers supply state; park answer is prompt or never
`timescale 1ns/10ps
module pursq_supervisor (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic supplies_up_i,
    input wire logic drop_i,
    input wire logic slow_i,
    input wire logic park_request_i,
    input wire logic pll_powerdown_i,
    output logic sense_o,
    output logic warning_o,
    output logic park_done_o,
    output logic locked_o
);
    logic [2:0] park_cnt;
    logic [2:0] lock_cnt;
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sense_o <= 1'b0;
            warning_o <= 1'b1;
            park_done_o <= 1'b0;
            locked_o <= 1'b0;
            park_cnt <= 3'h0;
            lock_cnt <= 3'h0;
        end else begin
            // sense stays low until every rail is up and settled
            sense_o <= supplies_up_i;
            warning_o <= !drop_i;
            park_cnt <= park_request_i ? park_cnt + 3'h1 : 3'h0;
            // slow mirrors never answer, so the timeout path is taken
            park_done_o <= park_request_i && !slow_i && park_cnt == 3'h2;
            lock_cnt <= pll_powerdown_i ? 3'h0 : (lock_cnt == 3'h7 ? lock_cnt : lock_cnt + 3'h1);
            locked_o <= lock_cnt == 3'h7;
        end
    end
endmodule // pursq_supervisor

// >>> sim/testbench.sv
// testbench.sv: self-checking bench for the power-up reset sequencer
// assumes a shortened lock delay and park timeout; supervisor model drives supply pins
`timescale 1ns/10ps
module testbench;
    import pursq_pkg::*;
    logic core_clk_i, reset_i, sense, warning, watchdog, park_done, locked, err_flag;
    logic supplies_up, drop, slow;
    pursq_fw_cmd_s fw_cmd;
    pursq_ctrl_s ctrl, exp;
    logic [7:0] link_rate, exp_rate, rate_r;
    logic exp_err;
    logic [22:0] obs, last;
    logic [22:0] q[$];
    int fails, cmp_count, cycles;
    integer seed;
    assign obs = {ctrl, link_rate, err_flag};

    pursq_sequencer #(.LOCK_DELAY_CYC(20), .PARK_TIMEOUT_CYC(8)) u_dut (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .power_on_sense_i(sense),
        .supply_good_warning_i(warning), .watchdog_timeout_i(watchdog),
        .park_done_i(park_done), .mirror_link_pll_locked_i(locked), .fw_cmd_i(fw_cmd),
        .ctrl_o(ctrl), .link_rate_o(link_rate), .bringup_error_o(err_flag));
    pursq_supervisor u_sup (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .supplies_up_i(supplies_up),
        .drop_i(drop), .slow_i(slow), .park_request_i(ctrl.park_request),
        .pll_powerdown_i(ctrl.mirror_link_pll_powerdown), .sense_o(sense),
        .warning_o(warning), .park_done_o(park_done), .locked_o(locked));

    always #12.5 core_clk_i = ~core_clk_i;

    task automatic print_verdict();
        if (fails == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [22:0] seen, input logic [22:0] want);
        cmp_count++;
        if (seen !== want) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, want, seen);
        end
    endtask
    task automatic note();
        q.push_back({exp, exp_rate, exp_err});
    endtask
    task automatic set_default();
        exp = '1;
        exp.link_clock_enable = 1'b0;
        exp.boot_from_flash = 1'b0;
        exp.park_request = 1'b0;
        exp_rate = 8'h00;
        exp_err = 1'b0;
    endtask
    task automatic boot_note();
        exp.cpu_reset = 1'b0;
        exp.io_tristate = 1'b0;
        exp.boot_from_flash = 1'b1;
        note();
    endtask
    // system reset without power loss keeps the primary pll running
    task automatic hold_note();
        set_default();
        exp.primary_pll_reset = 1'b0;
        exp.io_tristate = 1'b0;
        note();
        boot_note();
    endtask
    task automatic fw(input logic [6:0] bits);
        @(posedge core_clk_i);
        fw_cmd <= {rate_r, bits};
        @(posedge core_clk_i);
        fw_cmd <= {rate_r, 7'h00};
        repeat (6) @(posedge core_clk_i);
    endtask
    task automatic drain(input int n);
        repeat (n) if (q.size() != 0) @(posedge core_clk_i);
    endtask

    // outputs are registered, so they are compared away from the launching edge
    always @(negedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            last <= obs;
        end else if (obs !== last) begin
            last <= obs;
            if (q.size() == 0) check("unexpected", obs, last);
            else check("ctrl", obs, q.pop_front());
        end
    end
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails++;
            print_verdict();
        end
    end

    initial begin
        seed = 32'h8F2B3A54;
        core_clk_i = 1'b0;
        reset_i = 1'b1;
        supplies_up = 1'b0;
        drop = 1'b0;
        slow = 1'b0;
        watchdog = 1'b0;
        fw_cmd = '0;
        rate_r = 8'h00;
        fails = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (3) @(posedge core_clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        set_default();
        check("defaults", obs, {exp, exp_rate, exp_err});
        for (int pass = 0; pass < 2; pass++) begin
            exp.primary_pll_reset = 1'b0;
            note();
            boot_note();
            supplies_up <= 1'b1;
            drain(60);
            rate_r = 8'($random(seed)) | 8'h01;
            exp_err = 1'b1;
            note();
            fw(7'h20);
            exp_rate = rate_r;
            note();
            fw(7'h40);
            exp.mirror_link_pll_powerdown = 1'b0;
            note();
            fw(7'h20);
            repeat (12) @(posedge core_clk_i);
            fw(7'h10);
            exp.link_divider_reset = 1'b0;
            exp.link_clock_enable = 1'b1;
            note();
            fw(7'h08);
            exp.others_reset = 1'b0;
            exp.gpio_tristate = 1'b0;
            note();
            fw(7'h01);
            exp.lvds_powerdown = 1'b0;
            exp.lvds_reset = 1'b0;
            note();
            fw(7'h02);
            repeat (16) @(posedge core_clk_i);
            exp.external_reset = 1'b0;
            note();
            // leaving boot for run drops the flash boot flag one edge later
            exp.boot_from_flash = 1'b0;
            note();
            fw(7'h04);
            hold_note();
            @(posedge core_clk_i);
            watchdog <= 1'b1;
            @(posedge core_clk_i);
            watchdog <= 1'b0;
            drain(20);
            for (int s = 0; s < 2; s++) begin
                exp.park_request = 1'b1;
                exp.boot_from_flash = 1'b0;
                note();
                hold_note();
                slow <= s[0];
                drop <= 1'b1;
                repeat (30) @(posedge core_clk_i);
                drop <= 1'b0;
                drain(20);
            end
            set_default();
            note();
            supplies_up <= 1'b0;
            drain(30);
        end
        drain(20);
        check("pending", 23'(q.size()), 23'h000000);
        print_verdict();
    end
endmodule // testbench
